/* design/pcg_clock_ctrl.sv */
// Loop clock generator control: three 8-bit registers on APB, source switch,
// lock flag and interrupt. Assumes crystal and VCO clock levels arrive as
// inputs synchronous to clk, and that the analog loop supplies lock/track.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module pcg_clock_ctrl
  import pcg_pkg::*;
#(
  parameter int XLOSS_TIMEOUT = 64
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System side
  input  wire logic        oscillator_enable_in,
  input  wire logic        stop_mode,
  input  wire logic        crystal_clock,
  input  wire logic        vco_clock,
  input  wire logic        loop_locked,
  input  wire logic        loop_tracking,
  output logic             osc_run,
  output logic             loop_run,
  output logic             base_clock_out,
  output logic             lock_interrupt_out,
  output logic [3:0]       feedback_divide,
  output logic [3:0]       range_setting,
  output logic             track_force
);
  import pcg_pkg::*;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic acc, wr, rd, sel_ctl, sel_bw, sel_mul;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign sel_ctl = (paddr == PCG_PLL_CONTROL_ADDR);
  assign sel_bw  = (paddr == PCG_LOOP_BANDWIDTH_ADDR);
  assign sel_mul = (paddr == PCG_LOOP_MULT_ADDR);
  assign pready  = 1'b1;
  assign pslverr = acc && !(sel_ctl || sel_bw || sel_mul);

  // ----------------------------------------------------------------------
  // Control and bandwidth state
  // ----------------------------------------------------------------------
  logic       irq_en_q, flag_q, pwr_q, src_q, auto_q, track_q;
  logic       lock_q, xloss_q;
  logic [3:0] mult_q, range_q;
  logic [7:0] wd;
  logic       lock_vis, lock_vis_prev_q;
  assign wd       = pwdata[7:0];
  assign lock_vis = auto_q && loop_locked;

  always_ff @(posedge clk) begin
    if (srst) begin
      auto_q  <= 1'b0;
      track_q <= 1'b0;
    end else if (wr && sel_bw) begin
      auto_q <= wd[PCG_BW_AUTO_BIT];
      if (!auto_q) begin
        track_q <= wd[PCG_BW_TRACK_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_en_q <= 1'b0;
    end else if (!auto_q) begin
      irq_en_q <= 1'b0;
    end else if (wr && sel_ctl) begin
      irq_en_q <= wd[PCG_CTL_IRQ_EN_BIT];
    end
  end

  // Power-on and source select interlock
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_q <= 1'b1;
      src_q <= 1'b0;
    end else begin
      if (wr && sel_ctl) begin
        // Power and source never flip against each other in one write
        if (!wd[PCG_CTL_PWR_BIT] && !wd[PCG_CTL_SRC_BIT] && !src_q) begin
          pwr_q <= 1'b0;
        end else if (wd[PCG_CTL_PWR_BIT]) begin
          pwr_q <= 1'b1;
        end
        if (wd[PCG_CTL_SRC_BIT] && pwr_q && range_q != PCG_ZERO_NIB) begin
          src_q <= 1'b1;
        end else if (!wd[PCG_CTL_SRC_BIT]) begin
          src_q <= 1'b0;
        end
      end
      if (stop_mode || range_q == PCG_ZERO_NIB) begin
        src_q <= 1'b0;
      end
    end
  end

  // Multiplier and range fields
  always_ff @(posedge clk) begin
    if (srst) begin
      mult_q  <= PCG_MULT_RESET;
      range_q <= PCG_RANGE_RESET;
    end else if (wr && sel_mul && !pwr_q) begin
      mult_q  <= wd[7:4];
      range_q <= wd[3:0];
    end
  end

  // Lock indicator and lock-change flag; set wins over read clear
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_q          <= 1'b0;
      lock_vis_prev_q <= 1'b0;
      flag_q          <= 1'b0;
    end else begin
      lock_q          <= lock_vis;
      lock_vis_prev_q <= lock_vis;
      if (auto_q && lock_vis != lock_vis_prev_q) begin
        flag_q <= 1'b1;
      end else if (rd && sel_ctl) begin
        flag_q <= 1'b0;
      end else if (!auto_q) begin
        flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crystal loss detection: crystal edges restart a timeout
  // ----------------------------------------------------------------------
  logic        xtal_prev_q;
  logic [15:0] xcnt_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      xtal_prev_q <= 1'b0;
      xcnt_q      <= 16'h0000;
      xloss_q     <= 1'b0;
    end else begin
      xtal_prev_q <= crystal_clock;
      if (!src_q) begin
        xcnt_q  <= 16'h0000;
        xloss_q <= 1'b0;
      end else if (crystal_clock != xtal_prev_q) begin
        xcnt_q <= 16'h0000;
        if (wr && sel_bw && wd[PCG_BW_XLOSS_BIT]) begin
          xloss_q <= 1'b1;
        end else begin
          xloss_q <= 1'b0;
        end
      end else begin
        if (wr && sel_bw && wd[PCG_BW_XLOSS_BIT]) begin
          xloss_q <= 1'b1;
        end else if (xcnt_q >= 16'(XLOSS_TIMEOUT)) begin
          xloss_q <= 1'b1;
        end
        if (xcnt_q < 16'(XLOSS_TIMEOUT)) begin
          xcnt_q <= xcnt_q + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source switch: hold output, count edges of both clocks, then swap
  // ----------------------------------------------------------------------
  pcg_sw_state_t sw_q;
  logic       cur_src_q, vco_prev_q, xr_prev_q, div_q;
  logic [1:0] xe_q, ve_q;
  logic       xr_rise, vr_rise, src_clk;
  assign xr_rise = crystal_clock && !xr_prev_q;
  assign vr_rise = vco_clock && !vco_prev_q;
  assign src_clk = cur_src_q ? vco_clock : crystal_clock;

  always_ff @(posedge clk) begin
    if (srst) begin
      sw_q       <= PCG_RUN;
      cur_src_q  <= 1'b0;
      xe_q       <= 2'h0;
      ve_q       <= 2'h0;
      xr_prev_q  <= 1'b0;
      vco_prev_q <= 1'b0;
    end else begin
      xr_prev_q  <= crystal_clock;
      vco_prev_q <= vco_clock;
      unique case (sw_q)
        PCG_RUN: begin
          xe_q <= 2'h0;
          ve_q <= 2'h0;
          if (src_q != cur_src_q) begin
            sw_q <= PCG_HOLD;
          end
        end
        PCG_HOLD: begin
          if (xr_rise && xe_q < PCG_SWITCH_CYCLES) begin
            xe_q <= xe_q + 2'h1;
          end
          if ((vr_rise || !loop_run) && ve_q < PCG_SWITCH_CYCLES) begin
            ve_q <= ve_q + 2'h1;
          end
          if (xe_q == PCG_SWITCH_CYCLES && ve_q == PCG_SWITCH_CYCLES) begin
            sw_q <= PCG_SWAP;
          end
        end
        PCG_SWAP: begin
          cur_src_q <= src_q;
          sw_q      <= PCG_RUN;
        end
        default: sw_q <= PCG_RUN;
      endcase
    end
  end

  // Halve the selected source on its rising edges; frozen while switching
  logic src_prev_q;
  always_ff @(posedge clk) begin
    if (srst || stop_mode) begin
      src_prev_q <= 1'b0;
      div_q      <= 1'b0;
    end else begin
      src_prev_q <= src_clk;
      if (sw_q == PCG_RUN && src_clk && !src_prev_q) begin
        div_q <= !div_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic [7:0] rd_ctl, rd_bw, rd_mul;
  always_comb begin
    rd_ctl = {irq_en_q && auto_q, flag_q && auto_q, pwr_q, src_q,
              PCG_UNUSED_READ};
    rd_bw  = {auto_q, lock_q && auto_q,
              auto_q ? loop_tracking : track_q,
              xloss_q && src_q, PCG_ZERO_NIB};
    rd_mul = {mult_q, range_q};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == PCG_PLL_CONTROL_ADDR) begin
        prdata[7:0] <= rd_ctl;
      end else if (paddr == PCG_LOOP_BANDWIDTH_ADDR) begin
        prdata[7:0] <= rd_bw;
      end else if (paddr == PCG_LOOP_MULT_ADDR) begin
        prdata[7:0] <= rd_mul;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      osc_run            <= 1'b0;
      loop_run           <= 1'b0;
      lock_interrupt_out <= 1'b0;
      feedback_divide    <= PCG_ONE_NIB;
      range_setting      <= PCG_RANGE_RESET;
      track_force        <= 1'b0;
      base_clock_out     <= 1'b0;
    end else begin
      osc_run  <= oscillator_enable_in;
      loop_run <= oscillator_enable_in && pwr_q && range_q != PCG_ZERO_NIB;
      lock_interrupt_out <= flag_q && irq_en_q && auto_q && !stop_mode;
      feedback_divide <= (mult_q == PCG_ZERO_NIB) ? PCG_ONE_NIB : mult_q;
      range_setting   <= range_q;
      track_force     <= auto_q ? loop_tracking : track_q;
      base_clock_out  <= div_q && !stop_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  pwr_keep_a: assert property (@(posedge clk) disable iff (srst)
    src_q |-> pwr_q) else $error("power off while vco selected");
  src_guard_a: assert property (@(posedge clk) disable iff (srst)
    (!pwr_q && !src_q) |=> !src_q) else $error("source set with loop off");
  mult_hold_a: assert property (@(posedge clk) disable iff (srst)
    pwr_q |=> $stable(mult_q)) else $error("multiplier changed while on");
  irq_level_a: assert property (@(posedge clk) disable iff (srst)
    (flag_q && irq_en_q && auto_q && !stop_mode) |=> lock_interrupt_out)
    else $error("interrupt not raised");
  flag_clear_a: assert property (@(posedge clk) disable iff (srst)
    (rd && sel_ctl && !(auto_q && lock_vis != lock_vis_prev_q)) |=> !flag_q)
    else $error("flag survived read");
  flag_set_a: assert property (@(posedge clk) disable iff (srst)
    (auto_q && $changed(lock_vis)) |=> flag_q) else $error("flag not set");
  irqen_manual_a: assert property (@(posedge clk) disable iff (srst)
    !auto_q |=> !irq_en_q) else $error("enable held in manual");
  div_zero_a: assert property (@(posedge clk) disable iff (srst)
    (mult_q == PCG_ZERO_NIB) |=> feedback_divide == PCG_ONE_NIB)
    else $error("zero multiplier not one");
  // Stop may zero the divider mid-switch; that is a forced low, not a glitch
  hold_still_a: assert property (@(posedge clk) disable iff (srst)
    (sw_q == PCG_HOLD && !stop_mode) |=> $stable(div_q))
    else $error("output moved in switch");
  xloss_off_a: assert property (@(posedge clk) disable iff (srst)
    !src_q |=> !xloss_q) else $error("loss kept without vco");

  // Field protection, interlocks and output copies
  src_range_a: assert property (@(posedge clk) disable iff (srst)
    (range_q == PCG_ZERO_NIB) |=> !src_q) else $error("source kept at zero range");
  range_hold_a: assert property (@(posedge clk) disable iff (srst)
    pwr_q |=> $stable(range_q)) else $error("range changed while on");
  loop_gate_a: assert property (@(posedge clk) disable iff (srst)
    !pwr_q |=> !loop_run) else $error("loop run while off");
  osc_follow_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> (osc_run == $past(oscillator_enable_in))) else $error("oscillator run lags");
  fb_copy_a: assert property (@(posedge clk) disable iff (srst)
    (mult_q != PCG_ZERO_NIB) |=> (feedback_divide == $past(mult_q)))
    else $error("multiplier not passed on");

  // Lock flag, bandwidth mode and interrupt
  irqen_write_a: assert property (@(posedge clk) disable iff (srst)
    (auto_q && wr && sel_ctl) |=> (irq_en_q == $past(wd[PCG_CTL_IRQ_EN_BIT])))
    else $error("enable write lost");
  flag_manual_a: assert property (@(posedge clk) disable iff (srst)
    !auto_q |=> !flag_q) else $error("flag kept in manual");
  lock_manual_a: assert property (@(posedge clk) disable iff (srst)
    !auto_q |=> !lock_q) else $error("lock shown in manual");
  track_keep_a: assert property (@(posedge clk) disable iff (srst)
    auto_q |=> $stable(track_q)) else $error("manual track value lost");
  track_out_a: assert property (@(posedge clk) disable iff (srst)
    !auto_q |=> (track_force == $past(track_q))) else $error("track not forced");
  irq_off_a: assert property (@(posedge clk) disable iff (srst)
    !irq_en_q |=> !lock_interrupt_out) else $error("interrupt while disabled");
  xloss_write_a: assert property (@(posedge clk) disable iff (srst)
    (src_q && wr && sel_bw && wd[PCG_BW_XLOSS_BIT]) |=> xloss_q)
    else $error("loss write ignored");

  // Clock path and stop
  div_track_a: assert property (@(posedge clk) disable iff (srst)
    (sw_q == PCG_RUN && !stop_mode && src_clk && !src_prev_q) |=> $changed(div_q))
    else $error("divider missed an edge");
  swap_done_a: assert property (@(posedge clk) disable iff (srst)
    (sw_q == PCG_SWAP) |=> (cur_src_q == $past(src_q))) else $error("swap took wrong source");
  src_stop_a: assert property (@(posedge clk) disable iff (srst)
    stop_mode |=> !src_q) else $error("source kept in stop");
  out_stop_a: assert property (@(posedge clk) disable iff (srst)
    stop_mode |=> (!base_clock_out && !lock_interrupt_out)) else $error("output high in stop");
endmodule // pcg_clock_ctrl

/* design/pcg_pkg.sv */
// Constants for the loop clock generator control block.
// Assumes an APB master with 32-bit data and byte addresses.
package pcg_pkg;
  // --------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [3:0] PCG_PLL_CONTROL_ADDR    = 4'h0;
  localparam logic [3:0] PCG_LOOP_BANDWIDTH_ADDR = 4'h4;
  localparam logic [3:0] PCG_LOOP_MULT_ADDR      = 4'h8;
  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int PCG_CTL_IRQ_EN_BIT  = 7;
  localparam int PCG_CTL_FLAG_BIT    = 6;
  localparam int PCG_CTL_PWR_BIT     = 5;
  localparam int PCG_CTL_SRC_BIT     = 4;
  localparam int PCG_BW_AUTO_BIT     = 7;
  localparam int PCG_BW_LOCK_BIT     = 6;
  localparam int PCG_BW_TRACK_BIT    = 5;
  localparam int PCG_BW_XLOSS_BIT    = 4;
  // --------------------------------------------------------------------
  // Reset values, fixed read values and the switch edge count
  // --------------------------------------------------------------------
  localparam logic [3:0] PCG_MULT_RESET   = 4'h6;
  localparam logic [3:0] PCG_RANGE_RESET  = 4'h6;
  localparam logic [3:0] PCG_UNUSED_READ  = 4'hf;
  localparam logic [3:0] PCG_ZERO_NIB     = 4'h0;
  localparam logic [3:0] PCG_ONE_NIB      = 4'h1;
  localparam logic [1:0] PCG_SWITCH_CYCLES = 2'h3;
  // Switch sequencer states, one bit changing per step except SWAP back to RUN
  typedef enum logic [1:0] {
    PCG_RUN   = 2'b00,
    PCG_HOLD  = 2'b01,
    PCG_SWAP  = 2'b11
  } pcg_sw_state_t;
endpackage

/* testbench/pcg_sys_model.sv */
// System-side model: crystal and VCO clock levels, analog lock state.
// Assumes the bench drives the run and lock requests on clk.
`timescale 1ns/1ps
module pcg_sys_model #(
  parameter int XH = 4,
  parameter int VH = 3
) (
  // Clock and controls
  input  wire logic clk,
  input  wire logic xtal_en,
  input  wire logic vco_en,
  input  wire logic lock_req,
  // Sources and loop state
  output logic      crystal_clock,
  output logic      vco_clock,
  output logic      loop_locked,
  output logic      loop_tracking
);
  int xc = 0;
  int vc = 0;
  initial begin
    crystal_clock = 1'b0;
    vco_clock     = 1'b0;
    loop_locked   = 1'b0;
    loop_tracking = 1'b0;
  end
  // A stopped source parks low, as a dead oscillator would
  always @(posedge clk) begin
    xc <= xtal_en ? (xc + 1) % XH : 0;
    vc <= vco_en ? (vc + 1) % VH : 0;
    if (!xtal_en) crystal_clock <= 1'b0;
    else if (xc == XH - 1) crystal_clock <= ~crystal_clock;
    if (!vco_en) vco_clock <= 1'b0;
    else if (vc == VH - 1) vco_clock <= ~vco_clock;
    loop_locked   <= lock_req;
    loop_tracking <= lock_req;
  end
endmodule // pcg_sys_model

/* testbench/pll_clock_generator_control_tb.sv */
// Bench for the loop clock control block: APB stimulus, model compare.
// Assumes the system-side model in pcg_sys_model.sv.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module pll_clock_generator_control_tb;
  import pcg_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0]  paddr = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'hac473fa8;
  logic        osc_en = 1'b1, stop_mode = 1'b0, xtal_en = 1'b1, lock_req = 1'b0;
  logic        pready, pslverr, perr, xclk, vclk, lkd, trk, osc_run, loop_run;
  logic        base_clock_out, lock_interrupt_out, track_force;
  logic [3:0]  feedback_divide, range_setting, m_fb = 4'h6, m_rg = 4'h6;
  logic        m_ie = 1'b0, m_fl = 1'b0, m_pw = 1'b1, m_src = 1'b0;
  logic        m_au = 1'b0, m_tr = 1'b0, m_xl = 1'b0;
  int          compares = 0, miscompares = 0;

  pcg_clock_ctrl #(.XLOSS_TIMEOUT(16)) u_dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_enable_in(osc_en),
    .stop_mode(stop_mode), .crystal_clock(xclk), .vco_clock(vclk), .loop_locked(lkd),
    .loop_tracking(trk), .osc_run(osc_run), .loop_run(loop_run),
    .base_clock_out(base_clock_out), .lock_interrupt_out(lock_interrupt_out),
    .feedback_divide(feedback_divide), .range_setting(range_setting),
    .track_force(track_force));
  pcg_sys_model #(.XH(4), .VH(3)) u_sys (.clk(clk), .xtal_en(xtal_en), .vco_en(loop_run),
    .lock_req(lock_req), .crystal_clock(xclk), .vco_clock(vclk), .loop_locked(lkd),
    .loop_tracking(trk));

  initial forever #5 clk = ~clk;

  // ------------------------------------------------------------------
  // Bus tasks and model
  // ------------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) begin
      miscompares++;
      summarize();
    end
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic s;
    apb(1'b1, a, d);
    s = d[4] & m_pw & (m_rg != 4'h0);
    if (a == PCG_PLL_CONTROL_ADDR) begin
      if (m_au) m_ie = d[7];
      m_pw = d[5] | (m_pw & (m_src | d[4]));
      m_src = s;
    end
    if (a == PCG_LOOP_BANDWIDTH_ADDR) begin
      if (!m_au) m_tr = d[5];
      m_au = d[7];
    end
    if (a == PCG_LOOP_MULT_ADDR && !m_pw) {m_fb, m_rg} = d;
  endtask
  task automatic rd(input logic [3:0] a);
    logic [31:0] e;
    e = (a == PCG_PLL_CONTROL_ADDR) ? {24'h0, m_ie & m_au, m_fl & m_au, m_pw, m_src, 4'hf} :
        (a == PCG_LOOP_BANDWIDTH_ADDR) ?
        {24'h0, m_au, m_au & lock_req, m_au ? lock_req : m_tr, m_xl, 4'h0} :
        (a == PCG_LOOP_MULT_ADDR) ? {24'h0, m_fb, m_rg} : 32'h0;
    apb(1'b0, a, 8'h0);
    `CHK("prdata", e, r)
    `CHK("pslverr", a > PCG_LOOP_MULT_ADDR, perr)
    if (a == PCG_PLL_CONTROL_ADDR) m_fl = 1'b0;
  endtask
  task automatic meas(input int h);
    int t;
    logic p;
    t = 0;
    repeat (40) @(negedge clk);
    p = base_clock_out;
    repeat (120) begin
      @(negedge clk);
      if (base_clock_out !== p) t++;
      p = base_clock_out;
    end
    `CHK("base_clock_out edges", 1'b1, (t >= 60 / h - 1 && t <= 60 / h + 1))
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(PCG_PLL_CONTROL_ADDR);
    rd(PCG_LOOP_BANDWIDTH_ADDR);
    rd(PCG_LOOP_MULT_ADDR);
    `CHK("feedback_divide", PCG_MULT_RESET, feedback_divide)
    rd(4'hc);
    wr(PCG_PLL_CONTROL_ADDR, 8'hbf);
    rd(PCG_PLL_CONTROL_ADDR);
    wr(PCG_LOOP_MULT_ADDR, 8'h35);
    rd(PCG_LOOP_MULT_ADDR);
    wr(PCG_PLL_CONTROL_ADDR, 8'h00);
    wr(PCG_PLL_CONTROL_ADDR, 8'h00);
    wr(PCG_PLL_CONTROL_ADDR, 8'h10);
    rd(PCG_PLL_CONTROL_ADDR);
    repeat (6) begin
      seed = xs(seed);
      osc_en <= seed[8];
      wr(PCG_LOOP_MULT_ADDR, seed[7:0]);
      repeat (2) @(negedge clk);
      `CHK("feedback_divide", (m_fb == 4'h0) ? 4'h1 : m_fb, feedback_divide)
      `CHK("range_setting", m_rg, range_setting)
      `CHK("osc_run", osc_en, osc_run)
      `CHK("loop_run", osc_en & m_pw & (m_rg != 4'h0), loop_run)
      rd(PCG_LOOP_MULT_ADDR);
    end
    wr(PCG_LOOP_MULT_ADDR, 8'h86);
    osc_en <= 1'b1;
    wr(PCG_LOOP_BANDWIDTH_ADDR, 8'h00);
    wr(PCG_PLL_CONTROL_ADDR, 8'h20);
    meas(4);
    wr(PCG_PLL_CONTROL_ADDR, 8'h30);
    rd(PCG_PLL_CONTROL_ADDR);
    meas(3);
    wr(PCG_PLL_CONTROL_ADDR, 8'h00);
    rd(PCG_PLL_CONTROL_ADDR);
    wr(PCG_PLL_CONTROL_ADDR, 8'h30);
    wr(PCG_LOOP_BANDWIDTH_ADDR, 8'h10);
    repeat (40) @(posedge clk);
    rd(PCG_LOOP_BANDWIDTH_ADDR);
    xtal_en <= 1'b0;
    wr(PCG_LOOP_BANDWIDTH_ADDR, 8'h10);
    m_xl = 1'b1;
    repeat (40) @(posedge clk);
    rd(PCG_LOOP_BANDWIDTH_ADDR);
    wr(PCG_PLL_CONTROL_ADDR, 8'h20);
    m_xl = 1'b0;
    rd(PCG_LOOP_BANDWIDTH_ADDR);
    xtal_en <= 1'b1;
    wr(PCG_LOOP_BANDWIDTH_ADDR, 8'h20);
    repeat (2) @(negedge clk);
    `CHK("track_force", 1'b1, track_force)
    wr(PCG_LOOP_BANDWIDTH_ADDR, 8'ha0);
    lock_req <= 1'b1;
    m_fl = 1'b1;
    repeat (8) @(posedge clk);
    rd(PCG_LOOP_BANDWIDTH_ADDR);
    wr(PCG_PLL_CONTROL_ADDR, 8'ha0);
    repeat (2) @(negedge clk);
    `CHK("lock_interrupt_out", 1'b1, lock_interrupt_out)
    rd(PCG_PLL_CONTROL_ADDR);
    repeat (3) @(negedge clk);
    `CHK("lock_interrupt_out", 1'b0, lock_interrupt_out)
    rd(PCG_PLL_CONTROL_ADDR);
    wr(PCG_LOOP_BANDWIDTH_ADDR, 8'h20);
    rd(PCG_LOOP_BANDWIDTH_ADDR);
    rd(PCG_PLL_CONTROL_ADDR);
    `CHK("track_force", 1'b1, track_force)
    wr(PCG_PLL_CONTROL_ADDR, 8'h30);
    stop_mode <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK("base_clock_out", 1'b0, base_clock_out)
    @(posedge clk);
    stop_mode <= 1'b0;
    m_src = 1'b0;
    rd(PCG_PLL_CONTROL_ADDR);
    summarize();
  end
endmodule // pll_clock_generator_control_tb
